// File: common/spm_pkg.sv
// Shared constants and types of the serial master/slave port and its host end
`default_nettype none
package spm_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SPM_OFS_DATA = 8'h08;
  localparam logic [7:0] SPM_OFS_CTRL = 8'h09;
  localparam logic [7:0] SPM_OFS_CFG = 8'h0A;
  localparam logic [7:0] SPM_OFS_MODE = 8'h0B;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SPM_CTRL_CS = 0;
  localparam int SPM_CTRL_MST = 1;
  localparam int SPM_CTRL_ODIS = 2;
  localparam int SPM_CTRL_RDCMD = 3;
  localparam int SPM_CTRL_AINC = 4;
  localparam int SPM_CTRL_SHARE = 5;
  localparam int SPM_CTRL_BUSY = 6;
  localparam int SPM_CFG_PINFN = 7;
  localparam int SPM_MODE_CPOL = 0;
  localparam int SPM_MODE_CPHA = 1;
  localparam int SPM_CMD_READ = 7;
  // ----------------------------------------------------------------
  // Reset values and keys
  // ----------------------------------------------------------------
  localparam logic [7:0] SPM_RST_DATA = 8'h00;
  localparam logic [7:0] SPM_RST_CTRL = 8'h11;
  localparam logic [7:0] SPM_RST_CFG = 8'h05;
  localparam logic [7:0] SPM_RST_MODE = 8'h00;
  localparam logic [7:0] SPM_SLAVE_KEY = 8'hA5;
  localparam logic [7:0] SPM_CMD_RD_BYTE = 8'h80;
  localparam logic [7:0] SPM_CMD_WR_BYTE = 8'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SPM_SYS_CLK_MHZ = 100;
  localparam int SPM_SCK_RATIO_MIN = 5;
  // Slave needs three clocks from a rising edge to valid read data
  localparam int SPM_HOST_HALF_CYC = (SPM_SCK_RATIO_MIN + 1) / 2 + 1;
  localparam logic [3:0] SPM_LAST_EDGE = 4'hF;
  localparam logic [5:0] SPM_FRAME_HALVES = 6'h2F;
  localparam logic [5:0] SPM_DATA_HALF = 6'h20;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SPM_PH_ADDR, SPM_PH_CMD, SPM_PH_DATA} spm_phase_t;
  typedef enum logic [1:0] {SPM_HS_IDLE, SPM_HS_RUN, SPM_HS_GAP} spm_host_st_t;
endpackage : spm_pkg
`default_nettype wire

// File: common/spm_link_if.sv
// Four-line serial link between the port and an external host
`timescale 1ns/10ps
`default_nettype none
interface spm_link_if;
  logic dev_cs_n, dev_cs_oe, dev_sck, dev_sck_oe;
  logic dev_do, dev_do_oe, dev_di, dev_di_oe;
  logic host_cs_n, host_cs_oe, host_sck, host_sck_oe, host_di, host_di_oe;
  logic cs_n, sck, di_line, do_line;
  // ----------------------------------------------------------------
  // Wire resolution, idle levels model pull-ups
  // ----------------------------------------------------------------
  assign cs_n = dev_cs_oe ? dev_cs_n : (host_cs_oe ? host_cs_n : 1'b1);
  assign sck = dev_sck_oe ? dev_sck : (host_sck_oe ? host_sck : 1'b1);
  assign di_line = dev_di_oe ? dev_di : (host_di_oe ? host_di : 1'b1);
  assign do_line = dev_do_oe ? dev_do : 1'b1;
  modport device (output dev_cs_n, dev_cs_oe, dev_sck, dev_sck_oe, dev_do, dev_do_oe,
                  dev_di, dev_di_oe, input cs_n, sck, di_line, do_line);
  modport host (output host_cs_n, host_cs_oe, host_sck, host_sck_oe, host_di, host_di_oe,
                input cs_n, sck, di_line, do_line);
endinterface : spm_link_if
`default_nettype wire

// File: src/spm_port.sv
// Serial port of the chip: byte master for the processor, register slave for a host
`timescale 1ns/10ps
`default_nettype none
module spm_port
  import spm_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  output logic [7:0] sys_addr,
  output logic [7:0] sys_wdata,
  output logic sys_wr,
  output logic sys_rd,
  input wire logic [7:0] sys_rdata,
  spm_link_if.device link
);
  logic [7:0] data_reg, cfg_reg, mode_reg;
  logic [5:0] ctrl_reg;
  logic busy, sck_t, rd_shift;
  logic [6:0] div_cnt;
  logic [3:0] edge_cnt;
  logic [7:0] tx_sh;
  logic sck_q, s_out;
  logic [2:0] s_bits;
  logic [7:0] s_rx, s_addr, s_tx, s_tsh;
  logic s_read, s_armed, s_fetch, s_cap;
  spm_phase_t s_phase;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic mst = ctrl_reg[SPM_CTRL_MST];
  wire logic pin_on = cfg_reg[SPM_CFG_PINFN];
  wire logic cpol = mode_reg[SPM_MODE_CPOL];
  wire logic cpha = mode_reg[SPM_MODE_CPHA];
  wire logic share = ctrl_reg[SPM_CTRL_SHARE];
  wire logic cpu_dat_wr = cpu_wr && cpu_addr == SPM_OFS_DATA;
  wire logic cpu_dat_rd = cpu_rd && cpu_addr == SPM_OFS_DATA;
  // Reads only start clocks with the read-command bit set
  wire logic start = mst && !busy && (cpu_dat_wr ||
                     (cpu_dat_rd && ctrl_reg[SPM_CTRL_RDCMD]));
  wire logic tick = busy && div_cnt == cfg_reg[6:0];
  wire logic sample = tick && edge_cnt[0] == cpha;
  wire logic launch = tick && edge_cnt[0] != cpha && edge_cnt != 4'h0;
  wire logic frame = !mst && !link.cs_n;
  wire logic rise = frame && link.sck && !sck_q;
  wire logic fall = frame && !link.sck && sck_q;
  wire logic [7:0] s_byte = {s_rx[6:0], link.di_line};
  wire logic s_last = rise && s_bits == 3'h7;
  wire logic s_is_local = s_addr[7:2] == SPM_OFS_DATA[7:2];
  wire logic s_key = s_addr == SPM_OFS_CFG && s_byte == SPM_SLAVE_KEY;
  // Writes before activation are dropped, except the key itself
  wire logic s_wr = s_last && s_phase == SPM_PH_DATA && !s_read
                    && (s_armed || s_key);

  function automatic logic [7:0] reg_rd(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      SPM_OFS_DATA: v = data_reg;
      SPM_OFS_CTRL: v = {1'b0, busy, ctrl_reg};
      SPM_OFS_CFG: v = cfg_reg;
      SPM_OFS_MODE: v = mode_reg;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_rd

  // ----------------------------------------------------------------
  // Register file, processor wins per register over a same-cycle slave write
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_reg <= SPM_RST_CTRL[5:0];
      cfg_reg <= SPM_RST_CFG;
      mode_reg <= SPM_RST_MODE;
    end else begin
      if (cpu_wr && cpu_addr == SPM_OFS_CTRL) ctrl_reg <= cpu_wdata[5:0];
      else if (s_wr && s_addr == SPM_OFS_CTRL) ctrl_reg <= s_byte[5:0];
      if (cpu_wr && cpu_addr == SPM_OFS_CFG) cfg_reg <= cpu_wdata;
      else if (s_wr && s_addr == SPM_OFS_CFG) cfg_reg <= s_byte;
      if (cpu_wr && cpu_addr == SPM_OFS_MODE) mode_reg <= cpu_wdata;
      else if (s_wr && s_addr == SPM_OFS_MODE) mode_reg <= s_byte;
    end
  end

  // Data register doubles as the master receive shifter
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      data_reg <= SPM_RST_DATA;
    end else if (cpu_dat_wr) begin
      data_reg <= cpu_wdata;
    end else if (s_wr && s_addr == SPM_OFS_DATA) begin
      data_reg <= s_byte;
    end else if (sample && rd_shift) begin
      data_reg <= {data_reg[6:0], link.di_line};
    end
  end

  // Processor read data stand one cycle after the strobe
  always_ff @(posedge clock or posedge reset) begin
    if (reset) cpu_rdata <= 8'h00;
    else cpu_rdata <= cpu_rd ? reg_rd(cpu_addr) : 8'h00;
  end

  // ----------------------------------------------------------------
  // Master clock generator, sixteen edges per byte
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      div_cnt <= 7'h00;
      edge_cnt <= 4'h0;
      sck_t <= 1'b0;
      rd_shift <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
      div_cnt <= 7'h00;
      edge_cnt <= 4'h0;
      rd_shift <= cpu_dat_rd;
    end else if (tick) begin
      div_cnt <= 7'h00;
      sck_t <= ~sck_t;
      edge_cnt <= edge_cnt + 4'h1;
      if (edge_cnt == SPM_LAST_EDGE) busy <= 1'b0;
    end else if (busy) begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  // Transmit shifter, first bit waits ahead of the first edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) tx_sh <= 8'h00;
    else if (start) tx_sh <= cpu_dat_wr ? cpu_wdata : data_reg;
    else if (launch) tx_sh <= {tx_sh[6:0], 1'b0};
  end

  // ----------------------------------------------------------------
  // Slave receive side
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) sck_q <= 1'b1;
    else sck_q <= link.sck;
  end

  // Frame sequencer: address byte, command byte, data bytes
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_bits <= 3'h0;
      s_rx <= 8'h00;
      s_phase <= SPM_PH_ADDR;
      s_addr <= 8'h00;
      s_read <= 1'b0;
      s_fetch <= 1'b0;
    end else if (!frame) begin
      s_bits <= 3'h0;
      s_phase <= SPM_PH_ADDR;
      s_fetch <= 1'b0;
    end else begin
      s_fetch <= 1'b0;
      if (rise) begin
        s_rx <= s_byte;
        s_bits <= s_bits + 3'h1;
      end
      if (s_last) begin
        unique case (s_phase)
          SPM_PH_ADDR: begin
            s_addr <= s_byte;
            s_phase <= SPM_PH_CMD;
          end
          SPM_PH_CMD: begin
            s_read <= s_byte[SPM_CMD_READ];
            s_fetch <= s_byte[SPM_CMD_READ];
            s_phase <= SPM_PH_DATA;
          end
          SPM_PH_DATA: begin
            if (ctrl_reg[SPM_CTRL_AINC]) s_addr <= s_addr + 8'h01;
            s_fetch <= s_read;
          end
        endcase
      end
    end
  end

  // Activation latch, set by the key write from the host
  always_ff @(posedge clock or posedge reset) begin
    if (reset) s_armed <= 1'b0;
    else if (s_wr && s_key) s_armed <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Slave register access, own registers served locally
  // ----------------------------------------------------------------
  assign sys_addr = s_addr;
  assign sys_wdata = s_byte;
  assign sys_wr = s_wr && !s_is_local;
  assign sys_rd = s_fetch && s_armed && !s_is_local;

  // Read data ready three clocks after the rising edge that asked
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_cap <= 1'b0;
      s_tx <= 8'h00;
    end else begin
      s_cap <= s_fetch;
      if (s_cap) s_tx <= !s_armed ? 8'h00 : (s_is_local ? reg_rd(s_addr) : sys_rdata);
    end
  end

  // Outgoing bit changes on falling edges only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_out <= 1'b0;
      s_tsh <= 8'h00;
    end else if (fall && s_bits == 3'h0) begin
      s_out <= s_tx[7];
      s_tsh <= {s_tx[6:0], 1'b0};
    end else if (fall) begin
      s_out <= s_tsh[7];
      s_tsh <= {s_tsh[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, one data direction at a time
  // ----------------------------------------------------------------
  logic m_drv, s_drv;
  assign m_drv = pin_on && mst && !ctrl_reg[SPM_CTRL_ODIS]
                 && !(share && rd_shift && busy);
  assign s_drv = pin_on && frame && s_read && s_phase == SPM_PH_DATA;
  assign link.dev_cs_n = ctrl_reg[SPM_CTRL_CS];
  assign link.dev_cs_oe = pin_on && mst;
  assign link.dev_sck = cpol ^ sck_t;
  assign link.dev_sck_oe = pin_on && mst;
  assign link.dev_do = mst ? tx_sh[7] : s_out;
  assign link.dev_do_oe = (m_drv || s_drv) && !share;
  assign link.dev_di = mst ? tx_sh[7] : s_out;
  assign link.dev_di_oe = (m_drv || s_drv) && share;
endmodule : spm_port
`default_nettype wire

// File: src/spm_host.sv
// External host end: one register access per frame toward the slave port
`timescale 1ns/10ps
`default_nettype none
module spm_host
  import spm_pkg::*;
#(
  parameter logic CPOL = 1'b0,
  parameter logic SHARE = 1'b0,
  parameter int HALF_CYC = SPM_HOST_HALF_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  spm_link_if.host link
);
  spm_host_st_t state;
  logic [7:0] hcnt;
  logic [5:0] h;
  logic [23:0] sh;
  logic [7:0] rx;
  logic rd_q;
  wire logic half_end = hcnt == 8'(HALF_CYC - 1);
  wire logic din = SHARE ? link.di_line : link.do_line;

  assign cmd_ready = state == SPM_HS_IDLE;

  // ----------------------------------------------------------------
  // Frame engine: 48 half periods, launch on even, sample at rise
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= SPM_HS_IDLE;
      hcnt <= 8'h00;
      h <= 6'h00;
      sh <= 24'h000000;
      rx <= 8'h00;
      rd_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      hcnt <= half_end ? 8'h00 : hcnt + 8'h01;
      unique case (state)
        SPM_HS_IDLE: begin
          hcnt <= 8'h00;
          if (cmd_valid) begin
            // Address, command, data; slave modes 0 and 3 only
            sh <= {cmd_addr, cmd_read ? SPM_CMD_RD_BYTE : SPM_CMD_WR_BYTE,
                   cmd_wdata};
            rd_q <= cmd_read;
            h <= 6'h00;
            state <= SPM_HS_RUN;
          end
        end
        SPM_HS_RUN: begin
          if (half_end) begin
            h <= h + 6'h01;
            // Sample on the rising edge only
            if (!h[0] && h >= SPM_DATA_HALF) rx <= {rx[6:0], din};
            if (h[0]) sh <= {sh[22:0], 1'b0};
            if (h == SPM_FRAME_HALVES) begin
              rsp_valid <= rd_q;
              rsp_data <= rd_q ? rx : 8'h00;
              state <= SPM_HS_GAP;
            end
          end
        end
        SPM_HS_GAP: begin
          if (half_end) state <= SPM_HS_IDLE;
        end
        default: state <= SPM_HS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pins; clock held at HALF_CYC system clocks per level
  // ----------------------------------------------------------------
  assign link.host_cs_n = state != SPM_HS_RUN;
  assign link.host_cs_oe = 1'b1;
  assign link.host_sck = state == SPM_HS_RUN ? h[0] : CPOL;
  assign link.host_sck_oe = 1'b1;
  assign link.host_di = sh[23];
  assign link.host_di_oe = state == SPM_HS_RUN
                           && !(SHARE && rd_q && h >= SPM_DATA_HALF);
endmodule : spm_host
`default_nettype wire

// File: sim/spm_chk.sv
// Link-level property checker for the serial port and its host end
`timescale 1ns/10ps
`default_nettype none
module spm_chk #(
  parameter logic CPOL = 1'b0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic do_line,
  input wire logic dev_sck_oe,
  input wire logic dev_cs_oe,
  input wire logic dev_do_oe,
  input wire logic dev_di_oe,
  input wire logic host_di_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Wire ownership
  // ----------------------------------------------------------------
  a_one_dir: assert property (!(dev_di_oe && host_di_oe))
    else $error("both ends drive the data line");
  a_single_out: assert property (dev_do_oe |-> !dev_di_oe)
    else $error("device drives both data lines");
  a_pins_paired: assert property (dev_sck_oe |-> dev_cs_oe)
    else $error("clock driven without chip select");
  // ----------------------------------------------------------------
  // Slave framing, seen from the host clock
  // ----------------------------------------------------------------
  // Two quiet cycles first, so the frame tail is not judged
  a_host_idle: assert property (!dev_sck_oe && cs_n && $past(cs_n) && $past(cs_n, 2)
    |-> sck == CPOL)
    else $error("host clock not at idle level");
  a_host_rate: assert property ($rose(sck) && !dev_sck_oe |=> !$rose(sck) [*4])
    else $error("host clock too fast");
  a_out_on_fall: assert property (dev_do_oe && $past(dev_do_oe) && !$stable(do_line)
    && !dev_sck_oe |-> !sck)
    else $error("slave output changed while clock high");
  a_clk_in_frame: assert property (!dev_sck_oe && !$stable(sck)
    |-> !cs_n || !$past(cs_n))
    else $error("host clock moved outside a frame");
  a_out_in_frame: assert property (!dev_sck_oe && dev_do_oe |-> !cs_n || !$past(cs_n))
    else $error("slave drives output outside a frame");
  c_master: cover property ($rose(dev_sck_oe));
  c_frame: cover property ($fell(cs_n) && !dev_sck_oe);
  c_slave_out: cover property (dev_do_oe && !dev_sck_oe);
endmodule : spm_chk
`default_nettype wire

// File: sim/spi_master_slave_port_tb.sv
// Self-checking bench: CPU and host traffic through the serial port
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_port_tb;
  import spm_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cpu_wr = 1'b0, cpu_rd = 1'b0, sys_wr, sys_rd;
  logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, cpu_rdata, sys_addr, sys_wdata;
  logic [7:0] sys_rdata = 8'h00;
  logic cmd_valid = 1'b0, cmd_ready, cmd_read = 1'b0, rsp_valid;
  logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00, rsp_data, d, v;
  logic [7:0] mem [256];
  logic [7:0] rst_v [4] = '{SPM_RST_DATA, SPM_RST_CTRL, SPM_RST_CFG, SPM_RST_MODE};
  logic exp_q [$];
  logic sck_q = 1'b0, do_seen = 1'b0, shr = 1'b0;
  int err_total = 0, total_checks = 0, cyc = 0, edges = 0, gap = 0, spd = 0, cpha = 0;
  int wr_cnt = 0, m;
  spm_link_if link ();
  spm_port spm_port_i (.clock(clock), .reset(reset), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
    .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_wr(sys_wr), .sys_rd(sys_rd),
    .sys_rdata(sys_rdata), .link(link));
  spm_host #(.CPOL(1'b1), .SHARE(1'b0)) spm_host_i (.clock(clock), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link(link));
  spm_chk #(.CPOL(1'b1)) spm_chk_i (.clock(clock), .reset(reset), .cs_n(link.cs_n),
    .sck(link.sck), .do_line(link.do_line), .dev_sck_oe(link.dev_sck_oe),
    .dev_cs_oe(link.dev_cs_oe), .dev_do_oe(link.dev_do_oe), .dev_di_oe(link.dev_di_oe),
    .host_di_oe(link.host_di_oe));
  always #5 clock = ~clock;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cpu_write(input logic [7:0] a, input logic [7:0] w);
    @(posedge clock);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= w;
    @(posedge clock);
    cpu_wr <= 1'b0;
  endtask : cpu_write
  // Read data stand only in the cycle after the strobe
  task automatic cpu_read(input logic [7:0] a, output logic [7:0] r);
    @(posedge clock);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge clock);
    cpu_rd <= 1'b0;
    #1 r = cpu_rdata;
  endtask : cpu_read
  task automatic wait_idle();
    repeat (300) begin
      cpu_read(SPM_OFS_CTRL, d);
      if (d[SPM_CTRL_BUSY] === 1'b0) break;
    end
    chk(8'(d[SPM_CTRL_BUSY]), 8'h00);
  endtask : wait_idle
  // Quiet a few cycles so enable changes on the clock pin are not counted
  task automatic arm();
    repeat (3) @(posedge clock);
    @(negedge clock);
    edges = 0;
    do_seen = 1'b0;
  endtask : arm
  // Control byte picks output disable and the shared data line
  task automatic xfer(input logic [7:0] mode, input logic [7:0] data, input logic [7:0] ctl);
    cpu_write(SPM_OFS_MODE, mode);
    cpu_write(SPM_OFS_CFG, 8'h80 | 8'(spd));
    cpu_write(SPM_OFS_CTRL, ctl);
    arm();
    cpha = int'(mode[SPM_MODE_CPHA]);
    shr = ctl[SPM_CTRL_SHARE];
    for (int i = 7; i >= 0; i--) if (!ctl[SPM_CTRL_ODIS]) exp_q.push_back(data[i]);
    cpu_write(SPM_OFS_DATA, data);
    cpu_read(SPM_OFS_CTRL, d);
    chk(8'(d[SPM_CTRL_BUSY]), 8'h01);
    wait_idle();
    chk(8'(edges), 8'h10);
    chk(8'(link.sck), 8'(mode[SPM_MODE_CPOL]));
    if (ctl[SPM_CTRL_ODIS] || shr) chk(8'(do_seen), 8'h00);
  endtask : xfer
  // One frame per access; wait bounded for the host to return idle
  task automatic host_op(input logic rd, input logic [7:0] a, input logic [7:0] w,
                         output logic [7:0] r);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_wdata <= w;
    do @(posedge clock); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    r = 8'h00;
    for (int i = 0; i < 600; i++) begin
      @(posedge clock);
      if (rsp_valid === 1'b1) r = rsp_data;
      if (i > 2 && cmd_ready === 1'b1) break;
    end
    chk(8'(cmd_ready), 8'h01);
  endtask : host_op
  // ----------------------------------------------------------------
  // Monitors and far-side system memory
  // ----------------------------------------------------------------
  // Master clock edges: spacing, count and sampled output bits
  always @(posedge clock) begin
    if (link.dev_sck_oe === 1'b1 && link.sck !== sck_q) begin
      // Level changes from mode writes between bytes land at sixteen and are skipped
      if (edges > 0 && edges < 16) chk(8'(gap), 8'(spd + 1));
      if (edges % 2 == cpha && exp_q.size() > 0)
        chk(8'(shr ? link.di_line : link.do_line), 8'(exp_q.pop_front()));
      edges++;
      gap = 1;
    end else gap++;
    if (link.dev_do_oe === 1'b1) do_seen = 1'b1;
    sck_q = link.sck;
  end
  // Read data invert when not asked for, so stale values never pass
  always @(posedge clock) begin
    if (sys_wr === 1'b1) begin
      mem[sys_addr] = sys_wdata;
      wr_cnt++;
    end
    sys_rdata <= (sys_rd === 1'b1) ? mem[sys_addr] : ~sys_rdata;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(36925));
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    foreach (rst_v[i]) begin
      cpu_read(SPM_OFS_DATA + 8'(i), d);
      chk(d, rst_v[i]);
    end
    v = 8'($urandom);
    cpu_write(SPM_OFS_MODE, v);
    cpu_write(8'h20, v);
    cpu_read(SPM_OFS_MODE, d);
    chk(d, v);
    cpu_read(8'h20, d);
    chk(d, 8'h00);
    $display("test registers done");
    for (m = 0; m < 4; m++) begin
      spd = (m == 0) ? 0 : int'($urandom % 4);
      xfer(8'(m), 8'($urandom), 8'h02);
    end
    xfer(8'h00, 8'h5A, 8'h06);
    xfer(8'h00, 8'($urandom), 8'h22);
    $display("test master write done");
    cpu_write(SPM_OFS_CTRL, 8'h03);
    repeat (2) @(posedge clock);
    #1 chk(8'(link.cs_n), 8'h01);
    cpu_write(SPM_OFS_CTRL, 8'h0A);
    repeat (2) @(posedge clock);
    #1 chk(8'(link.cs_n), 8'h00);
    arm();
    cpu_read(SPM_OFS_DATA, d);
    wait_idle();
    chk(8'(edges), 8'h10);
    cpu_write(SPM_OFS_CTRL, 8'h02);
    arm();
    cpu_read(SPM_OFS_DATA, d);
    chk(d, 8'hFF);
    repeat (40) @(posedge clock);
    chk(8'(edges), 8'h00);
    $display("test master read done");
    // Slave used alone, no two-wire unit shares these pins
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    wr_cnt = 0;
    host_op(1'b0, 8'h40, 8'h3C, d);
    chk(8'(wr_cnt), 8'h00);
    host_op(1'b0, SPM_OFS_CFG, SPM_SLAVE_KEY, d);
    cpu_read(SPM_OFS_CFG, d);
    chk(d, SPM_SLAVE_KEY);
    v = 8'($urandom);
    host_op(1'b0, 8'h40, v, d);
    chk(mem[8'h40], v);
    chk(sys_addr, 8'h41);
    mem[8'h41] = 8'($urandom);
    host_op(1'b1, 8'h41, 8'h00, d);
    chk(d, mem[8'h41]);
    v = 8'($urandom);
    cpu_write(SPM_OFS_MODE, v);
    cpu_write(SPM_OFS_CTRL, 8'h01);
    host_op(1'b1, SPM_OFS_MODE, 8'h00, d);
    chk(d, v);
    chk(sys_addr, SPM_OFS_MODE);
    $display("test slave done");
    stop_test();
  end
endmodule : spi_master_slave_port_tb
`default_nettype wire
